/* File: src/acq_trigger_pkg.sv */
// package: register map, fields, modes and timing for the acquisition trigger controller
package acq_trigger_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFF_TRIG_SOURCE = 8'h10;
    localparam logic [7:0] OFF_POST_COUNT = 8'h14;
    localparam logic [7:0] OFF_STATUS_CTRL = 8'h18;
    localparam logic [7:0] OFF_ACQ_ENABLE = 8'h1c;
    localparam logic [7:0] OFF_TRIG_LEVEL = 8'h0c;
    localparam logic [7:0] OFF_CHAN_ENABLE = 8'h08;
    localparam logic [7:0] OFF_MODE_CTRL = 8'h04;
    localparam logic [7:0] OFF_SAMPLE_COUNT = 8'h00;
    // trigger source register fields
    localparam int SEL_LSB = 0;
    localparam int POL_BIT = 3;
    localparam int EXT_SEL_BIT = 2;
    // status register fields
    localparam int ST_NOT_FULL = 0;
    localparam int ST_HALF = 1;
    localparam int ST_NOT_EMPTY = 2;
    localparam int ST_COUNT_ZERO = 3;
    localparam int ST_TRIG_SEEN = 4;
    localparam int ST_ACQ = 5;
    // control register fields
    localparam int CTL_CLR_BUF = 0;
    localparam int CTL_CLR_TRIG = 1;
    localparam int MODE_START_BIT = 4;
    // buffer and counter sizes
    localparam int BUF_SAMPLES = 32768;
    localparam int BUF_AW = 15;
    localparam int POST_W = 16;
    localparam int LEVEL_W = 8;
    localparam int CHANNELS = 4;
    // reset values
    localparam logic [3:0] CHAN_EN_RESET = 4'h1;
    localparam logic [15:0] POST_RESET = 16'h0000;
    localparam logic [7:0] LEVEL_RESET = 8'h80;
    // timing
    localparam int CLK_MHZ = 25;
    localparam int START_LATENCY_NS = 350;
    localparam int START_LATENCY_CYC = (START_LATENCY_NS * CLK_MHZ + 999) / 1000;
    localparam int PIPE_CLOCKS = 8;

    typedef enum logic [2:0]
    {
        MODE_SOFT = 3'h0,
        MODE_POST = 3'h1,
        MODE_PRE = 3'h2,
        MODE_MIDDLE = 3'h3,
        MODE_DELAY = 3'h4
    } acq_mode_t;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ARMED = 3'b001,
        ST_LATENCY = 3'b011,
        ST_RUN = 3'b010,
        ST_COUNT = 3'b110,
        ST_DONE = 3'b111
    } acq_state_t;

    typedef struct packed
    {
        logic valid;
        logic [CHANNELS*LEVEL_W-1:0] data;
    } sample_t;

    typedef struct packed
    {
        logic polarity;
        logic [2:0] select;
    } trig_cfg_t;
endpackage

/* File: src/acquisition_trigger_control.sv */
// trigger detection, acquisition modes, post-trigger counter and buffer write gating
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE1] post and middle modes start conversion a fixed 350 ns after trigger detection
// [RULE2] polarity 0 selects positive slope, 1 selects negative slope
// [RULE3] positive analog trigger fires on first below-to-above level crossing
// [RULE4] negative analog trigger fires on first above-to-below level crossing
// [RULE5] any of four channels may be the compared trigger signal
// [RULE6] external trigger detects rising or falling edge per polarity
// [RULE7] software mode triggers itself on the start command
// [RULE8] pre mode stores from start and stops at the trigger
// [RULE9] pre mode may give fewer samples, never more than requested
// [RULE10] middle mode counter decrements per sample after trigger, stops at zero
// [RULE11] middle mode acquires before and after trigger
// [RULE12] delay mode decrements preloaded counter per sample after trigger
// [RULE13] delay mode halts counter at zero then acquires
// [RULE14] post mode collects only after analog or external trigger
// [RULE15] sampling clock is a continuous pacer, pipeline needs 8 clocks
// [RULE16] on-board buffer holds 32K samples
// [RULE17] trigger threshold is an 8-bit code
// [RULE18] four single-ended channels, enabled by channel enable register; chanEnable is only stored, all four channels are always written
// [RULE19] post-trigger counter is 16-bit down counter
// [RULE20] writing post count register preloads counter at once
// [RULE21] external trigger ignores trigger level
// [RULE22] writing 1 to clear bit clears trigger-seen flag
// [RULE23] triggers armed only while enabled, flag sticky until cleared
// [RULE24] writes only inside acquisition window, stop when buffer full
module acquisition_trigger_control
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter stream, one strobe per sampling clock edge
    input wire acq_trigger_pkg::sample_t sampleIn,
    input wire logic externalEdgeTrigger,
    // buffer write port
    output logic bufWrite,
    output logic [acq_trigger_pkg::BUF_AW-1:0] bufAddr,
    output logic [31:0] bufData,
    input wire logic bufRead,
    // converter pacer gate
    output logic pacerRun
);
    import acq_trigger_pkg::*;

    logic rstMeta, rstSync;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end
    wire rstN = rstSync;

    trig_cfg_t trigCfg;
    acq_mode_t mode;
    logic [LEVEL_W-1:0] trigLevel;
    logic [CHANNELS-1:0] chanEnable;
    logic [POST_W-1:0] postCount;
    logic [BUF_AW:0] sampleLimit;
    logic acquisitionEnable;
    logic triggerSeenFlag;
    logic [BUF_AW:0] fill;
    logic [BUF_AW:0] stored;
    acq_state_t state;
    logic [3:0] latency;

    wire wrAcc = psel && penable && pwrite;
    wire rdAcc = psel && penable && !pwrite;
    wire wrPost = wrAcc && paddr == OFF_POST_COUNT;
    wire wrCtl = wrAcc && paddr == OFF_STATUS_CTRL;
    wire wrMode = wrAcc && paddr == OFF_MODE_CTRL;
    wire startCmd = wrMode && pwdata[MODE_START_BIT];
    wire clrTrig = wrCtl && pwdata[CTL_CLR_TRIG];
    wire clrBuf = wrCtl && pwdata[CTL_CLR_BUF];
    // a start write carries the new mode; the mode register only updates on that same edge
    acq_mode_t startMode;
    assign startMode = acq_mode_t'(pwdata[2:0]);
    wire mapped = paddr inside {OFF_TRIG_SOURCE, OFF_POST_COUNT, OFF_STATUS_CTRL,
        OFF_ACQ_ENABLE, OFF_TRIG_LEVEL, OFF_CHAN_ENABLE, OFF_MODE_CTRL, OFF_SAMPLE_COUNT};

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            trigCfg <= '0;
            mode <= MODE_SOFT;
            trigLevel <= LEVEL_RESET;
            chanEnable <= CHAN_EN_RESET;
            sampleLimit <= '0;
            acquisitionEnable <= 1'b0;
        end
        else if (wrAcc)
        begin
            case (paddr)
                OFF_TRIG_SOURCE: trigCfg <= {pwdata[POL_BIT], pwdata[2:0]}; // RULE2
                OFF_TRIG_LEVEL: trigLevel <= pwdata[LEVEL_W-1:0]; // RULE17
                OFF_CHAN_ENABLE: chanEnable <= pwdata[CHANNELS-1:0]; // RULE18
                OFF_MODE_CTRL: mode <= acq_mode_t'(pwdata[2:0]);
                OFF_SAMPLE_COUNT: sampleLimit <= pwdata[BUF_AW:0];
                OFF_ACQ_ENABLE: acquisitionEnable <= pwdata[0];
                default: ;
            endcase
        end
    end

    // analog compare on the selected channel; level ignored for the external source
    wire [1:0] chSel = trigCfg.select[1:0];
    wire [LEVEL_W-1:0] chSample = sampleIn.data[chSel*LEVEL_W +: LEVEL_W]; // RULE5
    logic aboveNow, abovePrev, abovePrevValid, extPrev;
    assign aboveNow = chSample > trigLevel;
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            abovePrev <= 1'b0;
            abovePrevValid <= 1'b0;
            extPrev <= 1'b0;
        end
        else
        begin
            extPrev <= externalEdgeTrigger;
            if (sampleIn.valid)
            begin
                abovePrev <= aboveNow;
                abovePrevValid <= state == ST_ARMED;
            end
        end
    end
    wire crossUp = sampleIn.valid && abovePrevValid && !abovePrev && aboveNow; // RULE3
    wire crossDown = sampleIn.valid && abovePrevValid && abovePrev && !aboveNow; // RULE4
    wire extRise = externalEdgeTrigger && !extPrev;
    wire extFall = !externalEdgeTrigger && extPrev;
    logic hwTrigger;
    always_comb
    begin
        if (trigCfg.select[EXT_SEL_BIT])
            hwTrigger = trigCfg.polarity ? extFall : extRise; // RULE6 RULE21
        else
            hwTrigger = trigCfg.polarity ? crossDown : crossUp; // RULE2
    end
    // only the armed state listens, so later crossings are not seen again
    wire trigEvent = acquisitionEnable && state == ST_ARMED && hwTrigger; // RULE23

    wire bufFull = fill == (BUF_AW+1)'(BUF_SAMPLES);
    wire limitHit = stored >= sampleLimit;
    wire sampleSlot = sampleIn.valid && !bufFull && !limitHit;
    wire countZero = postCount == '0;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state <= ST_IDLE;
            latency <= '0;
        end
        else if (!acquisitionEnable)
            state <= ST_IDLE;
        else
        begin
            case (state)
                ST_IDLE:
                    if (startCmd)
                        state <= (startMode == MODE_SOFT) ? ST_RUN : ST_ARMED; // RULE7
                ST_ARMED:
                    if (limitHit)
                        state <= ST_DONE; // RULE9
                    else if (trigEvent)
                    begin
                        latency <= 4'(START_LATENCY_CYC);
                        case (mode)
                            MODE_PRE: state <= ST_DONE; // RULE8
                            MODE_DELAY: state <= ST_COUNT; // RULE12
                            default: state <= ST_LATENCY; // RULE1
                        endcase
                    end
                ST_LATENCY:
                    if (latency <= 4'h1)
                        state <= (mode == MODE_MIDDLE) ? ST_COUNT : ST_RUN; // RULE1 RULE14
                    else
                        latency <= latency - 4'h1;
                ST_COUNT:
                    if (countZero)
                        state <= (mode == MODE_DELAY) ? ST_RUN : ST_DONE; // RULE13 RULE10
                ST_RUN:
                    if (limitHit || bufFull)
                        state <= ST_DONE; // RULE24
                ST_DONE:
                    if (startCmd)
                        state <= (startMode == MODE_SOFT) ? ST_RUN : ST_ARMED; // RULE7
                default: state <= ST_IDLE;
            endcase
        end
    end

    // post-trigger down counter, advanced by sample strobes
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            postCount <= POST_RESET;
        else if (wrPost)
            postCount <= pwdata[POST_W-1:0]; // RULE19 RULE20
        else if (state == ST_COUNT && sampleIn.valid && !countZero)
            postCount <= postCount - 16'h0001; // RULE10 RULE12
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            triggerSeenFlag <= 1'b0;
        else if (trigEvent || (startCmd && startMode == MODE_SOFT && acquisitionEnable))
            triggerSeenFlag <= 1'b1; // RULE23
        else if (clrTrig)
            triggerSeenFlag <= 1'b0; // RULE22
    end

    // pre-trigger phase stores while armed in pre and middle modes
    wire preWindow = state == ST_ARMED && (mode == MODE_PRE || mode == MODE_MIDDLE); // RULE11
    wire postWindow = state == ST_RUN || (state == ST_COUNT && mode == MODE_MIDDLE); // RULE14
    wire acquiring = preWindow || postWindow;
    wire doWrite = acquiring && sampleSlot; // RULE24

    logic [BUF_AW-1:0] wrPtr;
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            wrPtr <= '0;
            fill <= '0;
            stored <= '0;
            bufWrite <= 1'b0;
            bufAddr <= '0;
            bufData <= '0;
        end
        else
        begin
            bufWrite <= doWrite;
            if (doWrite)
            begin
                bufAddr <= wrPtr;
                bufData <= sampleIn.data;
                wrPtr <= wrPtr + 1'b1; // RULE16
            end
            if (clrBuf)
                fill <= '0;
            else if (doWrite && !(bufRead && fill != '0))
                fill <= fill + 1'b1;
            else if (!doWrite && bufRead && fill != '0)
                fill <= fill - 1'b1;
            if (startCmd)
                stored <= '0;
            else if (doWrite)
                stored <= stored + 1'b1; // RULE9
        end
    end

    // pacer never single-shots: it runs whenever acquisition is enabled
    assign pacerRun = acquisitionEnable; // RULE15

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                OFF_STATUS_CTRL: prdata <= {26'h0, acquiring, triggerSeenFlag, countZero,
                    fill != '0, fill >= (BUF_AW+1)'(BUF_SAMPLES/2), !bufFull};
                OFF_POST_COUNT: prdata <= {16'h0, postCount};
                OFF_SAMPLE_COUNT: prdata <= {16'h0, stored};
                OFF_CHAN_ENABLE: prdata <= {28'h0, chanEnable};
                default: prdata <= '0;
            endcase
        end
    end

    a_trig_flag_sticky: assert property (@(posedge clk) disable iff (!rstN) // RULE23
        triggerSeenFlag && !clrTrig |=> triggerSeenFlag)
        else $error("trigger flag dropped without clear");
    a_clear_flag: assert property (@(posedge clk) disable iff (!rstN) // RULE22
        clrTrig && !trigEvent && !startCmd |=> !triggerSeenFlag)
        else $error("trigger flag not cleared");
    a_preload_count: assert property (@(posedge clk) disable iff (!rstN) // RULE20
        wrPost |=> postCount == $past(pwdata[15:0]))
        else $error("post count not preloaded");
    a_count_stops: assert property (@(posedge clk) disable iff (!rstN) // RULE10
        countZero && !wrPost |=> countZero)
        else $error("counter moved past zero");
    // latency wait measured apart from the latency register, so a bad reload shows up
    logic [3:0] latCycles;
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            latCycles <= '0;
        else if (state == ST_LATENCY)
            latCycles <= latCycles + 4'h1;
        else
            latCycles <= '0;
    end
    sequence trig_to_latency;
        trigEvent && (mode == MODE_POST || mode == MODE_MIDDLE) && !limitHit;
    endsequence
    sequence latency_exit;
        state != ST_LATENCY && $past(state) == ST_LATENCY && $past(acquisitionEnable);
    endsequence
    a_latency_entry: assert property (@(posedge clk) disable iff (!rstN) // RULE1
        trig_to_latency |=> state == ST_LATENCY)
        else $error("latency wait not entered");
    a_start_latency: assert property (@(posedge clk) disable iff (!rstN) // RULE1
        latency_exit |-> latCycles == 4'(START_LATENCY_CYC))
        else $error("start latency wrong");
    a_soft_start: assert property (@(posedge clk) disable iff (!rstN) // RULE7
        state == ST_IDLE && acquisitionEnable && startCmd && startMode == MODE_SOFT
        |=> state == ST_RUN && triggerSeenFlag)
        else $error("software start did not run");
    a_pre_stops: assert property (@(posedge clk) disable iff (!rstN) // RULE8
        trigEvent && mode == MODE_PRE |=> !acquiring)
        else $error("pre mode kept acquiring");
    a_no_write_full: assert property (@(posedge clk) disable iff (!rstN) // RULE24
        bufFull |-> !doWrite)
        else $error("write into full buffer");
    a_delay_no_write: assert property (@(posedge clk) disable iff (!rstN) // RULE13
        state == ST_COUNT && mode == MODE_DELAY |-> !doWrite)
        else $error("delay mode wrote early");
    a_ext_edge: assert property (@(posedge clk) disable iff (!rstN) // RULE6
        state == ST_ARMED && acquisitionEnable && trigCfg.select[2] && !trigCfg.polarity
        && $rose(externalEdgeTrigger) && !limitHit |=> state != ST_ARMED)
        else $error("external rising edge missed");
endmodule // acquisition_trigger_control
`default_nettype wire

/* File: tb/afe_model.sv */
// model of the analog front end and the external trigger source
`timescale 1ns/1ps
`default_nettype none
module afe_model
(
    // clock
    input wire logic clk,
    // levels the bench wants presented
    input wire logic [31:0] chanLevel,
    input wire logic extLevel,
    // converter side
    output acq_trigger_pkg::sample_t sampleOut,
    output logic extTrig
);
    import acq_trigger_pkg::*;
    initial
    begin
        sampleOut = '0;
        extTrig = 1'b0;
    end
    // pacer never pauses, the converter pipeline needs a steady clock
    // data between strobes is inverted so stale values never look valid
    always @(posedge clk)
    begin
        sampleOut.valid <= ~sampleOut.valid;
        sampleOut.data <= sampleOut.valid ? ~chanLevel : chanLevel;
        extTrig <= extLevel;
    end
endmodule // afe_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking testbench for the acquisition trigger controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import acq_trigger_pkg::*;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic bufWrite, bufRead, pacerRun, ext, extLevel, slvErr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, chanLevel, rd, bufData;
    logic [BUF_AW-1:0] bufAddr;
    sample_t sampleIn;
    int error_cnt = 0;
    int n_checks = 0;
    int wrCnt = 0;

    acquisition_trigger_control acquisition_trigger_control_i (.clk(clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleIn(sampleIn),
        .externalEdgeTrigger(ext), .bufWrite(bufWrite), .bufAddr(bufAddr),
        .bufData(bufData), .bufRead(bufRead), .pacerRun(pacerRun));
    afe_model afe_model_i (.clk(clk), .chanLevel(chanLevel), .extLevel(extLevel),
        .sampleOut(sampleIn), .extTrig(ext));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // monotonic count, tasks take differences so no reset race
    always @(posedge clk)
        if (bufWrite === 1'b1)
            wrCnt <= wrCnt + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic status(input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, OFF_STATUS_CTRL, 32'h0);
        chk(rd & mask, exp);
    endtask

    task automatic prep(input logic [2:0] m, input logic [15:0] lim, input logic [15:0] pc,
        input logic [3:0] src, input logic [7:0] lvl);
        apb(1'b1, OFF_ACQ_ENABLE, 32'h0);
        apb(1'b1, OFF_STATUS_CTRL, 32'h3);
        apb(1'b1, OFF_SAMPLE_COUNT, {16'h0, lim});
        apb(1'b1, OFF_POST_COUNT, {16'h0, pc});
        apb(1'b1, OFF_TRIG_SOURCE, {28'h0, src});
        apb(1'b1, OFF_TRIG_LEVEL, {24'h0, lvl});
        apb(1'b1, OFF_CHAN_ENABLE, 32'hf);
        apb(1'b1, OFF_ACQ_ENABLE, 32'h1);
        chk({31'h0, pacerRun}, 32'h1);
        apb(1'b1, OFF_MODE_CTRL, 32'h10 | {29'h0, m});
    endtask

    task automatic t_soft;
        int b;
        b = wrCnt;
        chanLevel <= 32'h5a3c96e1;
        prep(MODE_SOFT, 16'h4, 16'h0, 4'h0, 8'h80);
        repeat (40) @(posedge clk);
        status(32'h10, 32'h10);
        chk(wrCnt - b, 4);
        chk(bufData, 32'h5a3c96e1);
        chk({17'h0, bufAddr}, 32'h3);
        apb(1'b1, OFF_STATUS_CTRL, 32'h2);
        status(32'h10, 32'h0);
    endtask

    task automatic t_trig(input acq_mode_t m, input logic pol, input logic [2:0] sel,
        input int pc, input int minCyc);
        int b, n;
        logic [7:0] lo, hi;
        logic [31:0] v;
        lo = pol ? 8'hc0 : 8'h40;
        hi = ~lo;
        extLevel <= pol;
        chanLevel <= {4{lo}};
        b = wrCnt;
        prep(m, m == MODE_MIDDLE ? 16'h100 : 16'h10, pc[15:0], {pol, sel}, sel[2] ? 8'hff : 8'h80);
        // other channels cross first, only the selected one may fire
        v = {4{hi}};
        if (!sel[2])
            v[8*sel[1:0] +: 8] = lo;
        chanLevel <= v;
        repeat (20) @(posedge clk);
        if (m != MODE_MIDDLE)
            chk(wrCnt - b, 0);
        status(32'h10, 32'h0);
        b = wrCnt;
        extLevel <= ~pol;
        chanLevel <= {4{hi}};
        n = 0;
        while (wrCnt == b && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n >= minCyc && n < 200}, 32'h1);
        repeat (60) @(posedge clk);
        status(32'h18, 32'h18);
        if (m != MODE_MIDDLE)
            chk(wrCnt - b, 16);
        b = wrCnt;
        repeat (20) @(posedge clk);
        chk(wrCnt - b, 0);
    endtask

    task automatic t_pre;
        int b;
        b = wrCnt;
        extLevel <= 1'b0;
        prep(MODE_PRE, 16'h6, 16'h0, 4'h4, 8'h80);
        repeat (60) @(posedge clk);
        chk(wrCnt - b, 6);
        b = wrCnt;
        prep(MODE_PRE, 16'h100, 16'h0, 4'h4, 8'h80);
        repeat (20) @(posedge clk);
        chk({31'h0, wrCnt > b}, 32'h1);
        extLevel <= 1'b1;
        repeat (20) @(posedge clk);
        b = wrCnt;
        repeat (20) @(posedge clk);
        chk(wrCnt - b, 0);
    endtask

    task automatic report_and_stop;
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop;
    end

    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        chanLevel = 32'h0;
        extLevel = 1'b0;
        bufRead = 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        status(32'h35, 32'h01);
        apb(1'b1, 8'h20, 32'h1);
        chk({31'h0, slvErr}, 32'h1);
        t_soft;
        t_trig(MODE_POST, 1'b0, 3'h2, 0, START_LATENCY_CYC);
        t_trig(MODE_POST, 1'b1, 3'h1, 0, START_LATENCY_CYC);
        t_trig(MODE_POST, 1'b0, 3'h3, 0, START_LATENCY_CYC);
        t_trig(MODE_MIDDLE, 1'b1, 3'h0, 3, 0);
        t_trig(MODE_POST, 1'b0, 3'h4, 0, START_LATENCY_CYC);
        t_trig(MODE_DELAY, 1'b1, 3'h4, 5, 9);
        t_pre;
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
